// ==== design/edge_qualifier.sv ====
// Edge qualifier: a comparator bit is accepted as a new level only after
// holding it for flt_len_i cycles, then rise/fall pulses and a slope-qualified hit pulse issue.
// Assumes raw_i is synchronous to mclk_i.
`timescale 1ns/100ps
module edge_qualifier
  import trig_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  // Comparator and setup
  input wire logic raw_i,
  input wire logic [`FLT_W-1:0] flt_len_i,
  input wire slope_t slope_i,
  // Qualified results
  output logic rise_o,
  output logic fall_o,
  output logic hit_o,
  output logic level_o
);
  logic [`FLT_W-1:0] cnt_ff;
  logic nxt_accept;

  // A change must persist: acts as the hysteresis band in time
  assign nxt_accept = (raw_i != level_o) &&
                      ((cnt_ff + 4'h1) >= flt_len_i);

  always_ff @(posedge mclk_i)
  begin
    if (rst_i || clr_i || raw_i == level_o)
      cnt_ff <= '0;
    else if (!nxt_accept)
      cnt_ff <= cnt_ff + 4'h1;
    else
      cnt_ff <= '0;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      level_o <= 1'b0;
    else if (clr_i)
      level_o <= raw_i;
    else if (nxt_accept)
      level_o <= raw_i;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i || clr_i)
    begin
      rise_o <= 1'b0;
      fall_o <= 1'b0;
      hit_o <= 1'b0;
    end
    else
    begin
      rise_o <= nxt_accept && raw_i;
      fall_o <= nxt_accept && !raw_i;
      hit_o <= nxt_accept && ((slope_i == SL_EITHER) ||
               (slope_i == SL_RISE && raw_i) ||
               (slope_i == SL_FALL && !raw_i));
    end
  end
endmodule

// ==== design/trig_consts.svh ====
// Constant set for the trigger qualification unit: source codes,
// counter widths and filter lengths. Assumes a 25 MHz system clock.
//
// Functional notes
// - Analog legal except for serial type; digital needs option, not video/runt/rise/serial.
// - External input is a legal source only for edge or video type.
// - Serial bus source is legal only with the serial-bus trigger type.
// - Hold-off on: events after a trigger ignored until time passes.
// - Edge mode fires when source crosses the level in chosen direction.
// - Slope rise, fall or either; either takes first edge after start.
// - Width detection uses the source channel threshold, not the level.
// - Hysteresis suppresses noisy re-crossings; none on external input.
// - Noise reject widens hysteresis; excludes high-freq suppress.
// - A/B mode checks B only after A was met; triggers on A then B.
// - Stage B has its own source, slope and hysteresis like stage A.
// - After-time mode waits programmed cycles after A, then checks B.
// - After-events delay triggers only on the n-th B event after A.
// - Positive pulse timed rise to fall, negative fall to rise, at threshold.
// - Greater mode fires on longer pulses, less mode on shorter pulses.
// - Equal: exact match at zero variation, else strictly inside band.
// - Unequal fires on mismatch with zero variation, else outside band.
// - Inside strictly within limits; outside below lower or above upper.
// - Loading one pair recomputes the other: centre/half-span or limits.
`ifndef TRIG_CONSTS_SVH
`define TRIG_CONSTS_SVH

// ----------------------------------------------------------------
// Source code map
// ----------------------------------------------------------------
`define SRC_W 5
`define SRC_ANA_BASE 5'h00
`define SRC_DIG_BASE 5'h04
`define SRC_EXT 5'h14
`define SRC_SBUS_BASE 5'h15
`define SRC_SBUS_LAST 5'h18

// ----------------------------------------------------------------
// Widths and filter lengths in clock cycles
// ----------------------------------------------------------------
`define CNT_W 24
`define EVT_W 16
`define FLT_W 4
`define HYST_AUTO_CYC 4'h2
`define HYST_SMALL_CYC 4'h1
`define HYST_MED_CYC 4'h2
`define HYST_LARGE_CYC 4'h4
`define NR_EXTRA_CYC 4'h4

`endif

// ==== design/trig_pkg.sv ====
// Types shared by the trigger qualification unit.
// Assumes trig_consts.svh is on the include path.
`include "trig_consts.svh"
package trig_pkg;

  typedef enum logic [3:0] {
    TT_EDGE = 4'h0, TT_AB = 4'h1, TT_WIDTH = 4'h2, TT_VIDEO = 4'h3,
    TT_PATTERN = 4'h4, TT_RUNT = 4'h5, TT_RISE = 4'h6,
    TT_TIMEOUT = 4'h7, TT_LINE = 4'h8, TT_SERIAL = 4'h9
  } trig_type_t;

  typedef enum logic [1:0] {
    SL_RISE = 2'h0, SL_FALL = 2'h1, SL_EITHER = 2'h2
  } slope_t;

  typedef enum logic [1:0] {
    HY_AUTO = 2'h0, HY_SMALL = 2'h1, HY_MED = 2'h2, HY_LARGE = 2'h3
  } hyst_t;

  typedef enum logic [2:0] {
    WC_GT = 3'h0, WC_LT = 3'h1, WC_EQ = 3'h2, WC_NE = 3'h3,
    WC_IN = 3'h4, WC_OUT = 3'h5
  } width_cmp_t;

  typedef enum logic [1:0] {
    AB_IDLE = 2'h0, AB_DELAY = 2'h1, AB_WAITB = 2'h2
  } ab_state_t;

endpackage

// ==== design/trig_unit.sv ====
// Trigger qualification unit: source selection, edge, A/B sequence and
// pulse-width triggers with hold-off. All comparator inputs are taken as
// synchronous to mclk_i; levels and thresholds are set outside.
`timescale 1ns/100ps
module trig_unit
  import trig_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Acquisition control
  input wire logic acq_start_i,
  input wire logic acq_stop_i,
  // Comparator inputs
  input wire logic [3:0] lvl_cmp_i,
  input wire logic [3:0] thr_cmp_i,
  input wire logic [15:0] dig_i,
  input wire logic ext_trig_i,
  input wire logic [3:0] sbus_i,
  // Type and source setup
  input wire trig_type_t trig_type_i,
  input wire logic msd_present_i,
  input wire logic [`SRC_W-1:0] src_a_i,
  input wire slope_t slope_a_i,
  input wire hyst_t hyst_a_i,
  input wire logic [`SRC_W-1:0] src_b_i,
  input wire slope_t slope_b_i,
  input wire hyst_t hyst_b_i,
  // Filter select strobes
  input wire logic hf_on_i,
  input wire logic nr_on_i,
  input wire logic filt_off_i,
  // A/B sequence setup
  input wire logic ab_events_i,
  input wire logic [`CNT_W-1:0] ab_delay_i,
  input wire logic [`EVT_W-1:0] ab_count_i,
  // Width setup
  input wire logic wpol_neg_i,
  input wire width_cmp_t wcmp_i,
  input wire logic ld_refvar_i,
  input wire logic ld_limits_i,
  input wire logic [`CNT_W-1:0] ref_i,
  input wire logic [`CNT_W-1:0] var_i,
  input wire logic [`CNT_W-1:0] lo_i,
  input wire logic [`CNT_W-1:0] hi_i,
  // Hold-off setup
  input wire logic holdoff_en_i,
  input wire logic [`CNT_W-1:0] holdoff_cyc_i,
  // Results and status
  output logic trig_o,
  output logic holdoff_busy_o,
  output logic src_err_o,
  output logic hf_suppress_o,
  output logic noise_rej_o,
  output logic wait_b_o,
  output logic [`CNT_W-1:0] ref_o,
  output logic [`CNT_W-1:0] var_o,
  output logic [`CNT_W-1:0] lo_o,
  output logic [`CNT_W-1:0] hi_o
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic pick_src(input logic [`SRC_W-1:0] sel,
                                    input logic use_thr);
    logic [`SRC_W-1:0] off;
    logic bit_v;
    off = '0;
    bit_v = 1'b0;
    if (sel < `SRC_DIG_BASE)
      bit_v = use_thr ? thr_cmp_i[sel[1:0]] : lvl_cmp_i[sel[1:0]];
    else if (sel < `SRC_EXT)
    begin
      off = sel - `SRC_DIG_BASE;
      bit_v = dig_i[off[3:0]];
    end
    else if (sel == `SRC_EXT)
      bit_v = ext_trig_i;
    else if (sel <= `SRC_SBUS_LAST)
    begin
      off = sel - `SRC_SBUS_BASE;
      bit_v = sbus_i[off[1:0]];
    end
    return bit_v;
  endfunction

  function automatic logic src_legal(input logic [`SRC_W-1:0] sel,
                                     input trig_type_t tt,
                                     input logic msd);
    logic ok;
    ok = 1'b0;
    if (sel < `SRC_DIG_BASE)
      ok = (tt != TT_SERIAL);
    else if (sel < `SRC_EXT)
      ok = msd && tt != TT_VIDEO && tt != TT_RUNT && tt != TT_RISE &&
           tt != TT_SERIAL;
    else if (sel == `SRC_EXT)
      ok = (tt == TT_EDGE) || (tt == TT_VIDEO);
    else if (sel <= `SRC_SBUS_LAST)
      ok = (tt == TT_SERIAL);
    return ok;
  endfunction

  function automatic logic [`FLT_W-1:0] hyst_len(input hyst_t hy,
                                                 input logic nr,
                                                 input logic ext);
    logic [`FLT_W-1:0] base;
    base = `HYST_AUTO_CYC;
    case (hy)
      HY_SMALL: base = `HYST_SMALL_CYC;
      HY_MED: base = `HYST_MED_CYC;
      HY_LARGE: base = `HYST_LARGE_CYC;
      default: base = `HYST_AUTO_CYC;
    endcase
    if (nr)
      base = base + `NR_EXTRA_CYC;
    if (ext)
      base = '0;
    return base;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic run_ff;
  logic clr;
  logic src_ok;
  logic qual_ok;
  logic raw_a;
  logic raw_b;
  logic a_rise;
  logic a_fall;
  logic a_hit;
  logic b_hit;
  logic a_lvl;
  logic [`CNT_W-1:0] ho_cnt_ff;
  ab_state_t ab_state_ff;
  logic [`CNT_W-1:0] ab_dcnt_ff;
  logic [`EVT_W-1:0] ab_ecnt_ff;
  logic [`EVT_W-1:0] ab_need;
  logic ab_fire;
  logic w_run_ff;
  logic [`CNT_W-1:0] w_cnt_ff;
  logic [`CNT_W-1:0] w_meas;
  logic w_start;
  logic w_end;
  logic w_match;
  logic w_fire;
  logic cand;

  // ----------------------------------------------------------------
  // Acquisition run state
  // ----------------------------------------------------------------
  // start clears state
  assign clr = acq_start_i || !run_ff;

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      run_ff <= 1'b0;
    else if (acq_start_i)
      run_ff <= 1'b1;
    else if (acq_stop_i)
      run_ff <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Filter selection
  // ----------------------------------------------------------------
  // exclusive filters
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || filt_off_i)
    begin
      hf_suppress_o <= 1'b0;
      noise_rej_o <= 1'b0;
    end
    else if (nr_on_i)
    begin
      // Both strobes together: noise reject is kept
      hf_suppress_o <= 1'b0;
      noise_rej_o <= 1'b1;
    end
    else if (hf_on_i)
    begin
      hf_suppress_o <= 1'b1;
      noise_rej_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Source selection and edge qualification
  // ----------------------------------------------------------------
  assign src_ok = src_legal(src_a_i, trig_type_i, msd_present_i) &&
                  (trig_type_i != TT_AB ||
                   src_legal(src_b_i, trig_type_i, msd_present_i));
  assign qual_ok = run_ff && src_ok && !holdoff_busy_o;

  assign raw_a = pick_src(src_a_i, trig_type_i == TT_WIDTH);
  assign raw_b = pick_src(src_b_i, 1'b0);

  edge_qualifier a_stage
  (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .clr_i(clr),
    .raw_i(raw_a),
    .flt_len_i(hyst_len(hyst_a_i, noise_rej_o, src_a_i == `SRC_EXT)),
    .slope_i(slope_a_i),
    .rise_o(a_rise),
    .fall_o(a_fall),
    .hit_o(a_hit),
    .level_o(a_lvl)
  );

  edge_qualifier b_stage
  (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .clr_i(clr),
    .raw_i(raw_b),
    .flt_len_i(hyst_len(hyst_b_i, noise_rej_o, src_b_i == `SRC_EXT)),
    .slope_i(slope_b_i),
    .rise_o(),
    .fall_o(),
    .hit_o(b_hit),
    .level_o()
  );

  // ----------------------------------------------------------------
  // Hold-off timer
  // ----------------------------------------------------------------
  // block after trigger
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || acq_start_i)
      ho_cnt_ff <= '0;
    else if (trig_o && holdoff_en_i)
      ho_cnt_ff <= holdoff_cyc_i;
    else if (ho_cnt_ff != '0)
      ho_cnt_ff <= ho_cnt_ff - 24'h000001;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i || acq_start_i)
      holdoff_busy_o <= 1'b0;
    else if (trig_o && holdoff_en_i && holdoff_cyc_i != '0)
      holdoff_busy_o <= 1'b1;
    else if (ho_cnt_ff <= 24'h000001)
      holdoff_busy_o <= 1'b0;
  end

  // ----------------------------------------------------------------
  // A/B sequence
  // ----------------------------------------------------------------
  // Zero programmed events is taken as one
  assign ab_need = (ab_count_i == '0) ? 16'h0001 : ab_count_i;

  assign ab_fire = (ab_state_ff == AB_WAITB) && b_hit &&
                   (!ab_events_i || (ab_ecnt_ff + 16'h0001) >= ab_need);

  always_ff @(posedge mclk_i)
  begin
    if (rst_i || clr || trig_type_i != TT_AB)
    begin
      ab_state_ff <= AB_IDLE;
      ab_dcnt_ff <= '0;
      ab_ecnt_ff <= '0;
    end
    else
    begin
      case (ab_state_ff)
        AB_IDLE:
        begin
          ab_ecnt_ff <= '0;
          if (a_hit && qual_ok)
          begin
            if (!ab_events_i && ab_delay_i != '0)
            begin
              ab_state_ff <= AB_DELAY;
              ab_dcnt_ff <= ab_delay_i;
            end
            else
              ab_state_ff <= AB_WAITB;
          end
        end
        AB_DELAY:
        begin
          ab_dcnt_ff <= ab_dcnt_ff - 24'h000001;
          if (ab_dcnt_ff <= 24'h000001)
            ab_state_ff <= AB_WAITB;
        end
        AB_WAITB:
        begin
          if (ab_fire)
            ab_state_ff <= AB_IDLE;
          else if (b_hit)
            ab_ecnt_ff <= ab_ecnt_ff + 16'h0001;
        end
        default: ab_state_ff <= AB_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      wait_b_o <= 1'b0;
    else
      wait_b_o <= (ab_state_ff != AB_IDLE) && !clr;
  end

  // ----------------------------------------------------------------
  // Pulse width measurement
  // ----------------------------------------------------------------
  // polarity timing
  assign w_start = wpol_neg_i ? a_fall : a_rise;
  assign w_end = wpol_neg_i ? a_rise : a_fall;

  // Counter saturates so very long pulses still read as long
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || clr || trig_type_i != TT_WIDTH)
    begin
      w_run_ff <= 1'b0;
      w_cnt_ff <= '0;
    end
    else if (w_start)
    begin
      w_run_ff <= 1'b1;
      w_cnt_ff <= '0;
    end
    else if (w_end)
      w_run_ff <= 1'b0;
    else if (w_run_ff && w_cnt_ff != {`CNT_W{1'b1}})
      w_cnt_ff <= w_cnt_ff + 24'h000001;
  end

  assign w_meas = (w_cnt_ff == {`CNT_W{1'b1}}) ? w_cnt_ff :
                  w_cnt_ff + 24'h000001;

  always_comb
  begin
    w_match = 1'b0;
    case (wcmp_i)
      WC_GT: w_match = w_meas > ref_o;
      WC_LT: w_match = w_meas < ref_o;
      WC_EQ: w_match = (var_o == '0) ? (w_meas == ref_o) :
                       (w_meas > lo_o && w_meas < hi_o);
      WC_NE: w_match = (var_o == '0) ? (w_meas != ref_o) :
                       (w_meas < lo_o || w_meas > hi_o);
      WC_IN: w_match = w_meas > lo_o && w_meas < hi_o;
      WC_OUT: w_match = w_meas < lo_o || w_meas > hi_o;
      default: w_match = 1'b0;
    endcase
  end

  assign w_fire = w_run_ff && w_end && w_match;

  width_window win
  (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ld_refvar_i(ld_refvar_i),
    .ld_limits_i(ld_limits_i),
    .ref_i(ref_i),
    .var_i(var_i),
    .lo_i(lo_i),
    .hi_i(hi_i),
    .ref_o(ref_o),
    .var_o(var_o),
    .lo_o(lo_o),
    .hi_o(hi_o)
  );

  // ----------------------------------------------------------------
  // Trigger output
  // ----------------------------------------------------------------
  always_comb
  begin
    case (trig_type_i)
      TT_EDGE: cand = a_hit;
      TT_AB: cand = ab_fire;
      TT_WIDTH: cand = w_fire;
      TT_SERIAL: cand = a_rise;
      default: cand = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i || acq_start_i)
      trig_o <= 1'b0;
    else
      trig_o <= cand && qual_ok && !trig_o;
  end

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      src_err_o <= 1'b0;
    else
      src_err_o <= !src_ok;
  end
endmodule

// ==== design/width_window.sv ====
// Keeps the reference/variation pair and the lower/upper limit pair of
// the width comparison consistent. Loads are single-cycle strobes.
`timescale 1ns/100ps
module width_window
  import trig_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Load strobes and values
  input wire logic ld_refvar_i,
  input wire logic ld_limits_i,
  input wire logic [`CNT_W-1:0] ref_i,
  input wire logic [`CNT_W-1:0] var_i,
  input wire logic [`CNT_W-1:0] lo_i,
  input wire logic [`CNT_W-1:0] hi_i,
  // Held pair values
  output logic [`CNT_W-1:0] ref_o,
  output logic [`CNT_W-1:0] var_o,
  output logic [`CNT_W-1:0] lo_o,
  output logic [`CNT_W-1:0] hi_o
);
  logic [`CNT_W:0] sum;
  logic [`CNT_W:0] span;

  assign sum = {1'b0, lo_i} + {1'b0, hi_i};
  assign span = {1'b0, hi_i} - {1'b0, lo_i};

  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      ref_o <= '0;
      var_o <= '0;
      lo_o <= '0;
      hi_o <= '0;
    end
    else if (ld_refvar_i)
    begin
      // Bounds clip at the counter range instead of wrapping
      ref_o <= ref_i;
      var_o <= var_i;
      lo_o <= (var_i > ref_i) ? '0 : ref_i - var_i;
      hi_o <= ({1'b0, ref_i} + {1'b0, var_i} > {1'b0, {`CNT_W{1'b1}}}) ?
              {`CNT_W{1'b1}} : ref_i + var_i;
    end
    else if (ld_limits_i)
    begin
      lo_o <= lo_i;
      hi_o <= hi_i;
      ref_o <= sum[`CNT_W:1];
      var_o <= span[`CNT_W] ? '0 : span[`CNT_W:1];
    end
  end
endmodule

// ==== test/trig_unit_chk.sv ====
// Checker for trig_unit, bound to its ports.
// Assumes one clock domain with sync reset.
`timescale 1ns/100ps
`include "trig_consts.svh"
module trig_unit_chk
  import trig_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Inputs watched
  input wire logic acq_start_i,
  input wire trig_type_t trig_type_i,
  input wire logic [`SRC_W-1:0] src_a_i,
  input wire logic hf_on_i,
  input wire logic nr_on_i,
  input wire logic filt_off_i,
  input wire logic ld_refvar_i,
  input wire logic [`CNT_W-1:0] ref_i,
  input wire logic [`CNT_W-1:0] var_i,
  input wire logic holdoff_en_i,
  input wire logic [`CNT_W-1:0] holdoff_cyc_i,
  // Outputs watched
  input wire logic trig_o,
  input wire logic holdoff_busy_o,
  input wire logic src_err_o,
  input wire logic hf_suppress_o,
  input wire logic noise_rej_o,
  input wire logic wait_b_o,
  input wire logic [`CNT_W-1:0] lo_o
);
  // ------------
  // Assertions
  // ------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  chk_trig_pulse: assert property (trig_o |=> !trig_o)
    else $error("trigger wider than one cycle");
  chk_hold_start: assert property (trig_o && holdoff_en_i &&
    holdoff_cyc_i != '0 && !acq_start_i |=> holdoff_busy_o)
    else $error("hold-off did not start");
  chk_hold_block: assert property (holdoff_busy_o |-> !trig_o)
    else $error("trigger during hold-off");
  chk_filt_excl: assert property (!(hf_suppress_o && noise_rej_o))
    else $error("both filters on");
  chk_nr_sel: assert property (nr_on_i && !filt_off_i |=>
    noise_rej_o && !hf_suppress_o)
    else $error("noise reject not selected");
  chk_hf_sel: assert property (hf_on_i && !nr_on_i && !filt_off_i
    |=> hf_suppress_o && !noise_rej_o)
    else $error("hf suppress not selected");
  chk_win_lower: assert property (ld_refvar_i && var_i <= ref_i
    |=> lo_o == $past(ref_i) - $past(var_i))
    else $error("lower limit wrong");
  chk_ext_width: assert property (trig_type_i == TT_WIDTH &&
    src_a_i == `SRC_EXT |=> src_err_o)
    else $error("external source accepted");
  chk_start_clr: assert property (acq_start_i |=> !wait_b_o)
    else $error("sequence not cleared");

  cov_ab: cover property (trig_o && trig_type_i == TT_AB);
  cov_width: cover property (trig_o && trig_type_i == TT_WIDTH);
  cov_hold: cover property ($rose(holdoff_busy_o));
endmodule

bind trig_unit trig_unit_chk u_chk (
  .mclk_i(mclk_i), .rst_i(rst_i), .acq_start_i(acq_start_i),
  .trig_type_i(trig_type_i), .src_a_i(src_a_i), .hf_on_i(hf_on_i),
  .nr_on_i(nr_on_i), .filt_off_i(filt_off_i),
  .ld_refvar_i(ld_refvar_i), .ref_i(ref_i), .var_i(var_i),
  .holdoff_en_i(holdoff_en_i), .holdoff_cyc_i(holdoff_cyc_i),
  .trig_o(trig_o), .holdoff_busy_o(holdoff_busy_o),
  .src_err_o(src_err_o), .hf_suppress_o(hf_suppress_o),
  .noise_rej_o(noise_rej_o), .wait_b_o(wait_b_o), .lo_o(lo_o)
);

// ==== test/trig_unit_tb.sv ====
// Self-checking bench for trig_unit, inputs set at rising edges.
// Assumes the checker is bound from its own file.
`timescale 1ns/100ps
`include "trig_consts.svh"
module trig_unit_tb
  import trig_pkg::*;
;
  logic mclk_i = 1'b0, rst_i, acq_start_i, acq_stop_i, ext_trig_i;
  logic [3:0] lvl_cmp_i, thr_cmp_i, sbus_i;
  logic [15:0] dig_i;
  trig_type_t trig_type_i;
  logic msd_present_i, hf_on_i, nr_on_i, filt_off_i, ab_events_i;
  logic [`SRC_W-1:0] src_a_i, src_b_i;
  slope_t slope_a_i, slope_b_i;
  hyst_t hyst_a_i, hyst_b_i;
  logic [`CNT_W-1:0] ab_delay_i, ref_i, var_i, lo_i, hi_i, holdoff_cyc_i;
  logic [`EVT_W-1:0] ab_count_i;
  logic wpol_neg_i, ld_refvar_i, ld_limits_i, holdoff_en_i;
  width_cmp_t wcmp_i;
  logic trig_o, holdoff_busy_o, src_err_o, hf_suppress_o, noise_rej_o;
  logic wait_b_o;
  logic [`CNT_W-1:0] ref_o, var_o, lo_o, hi_o;
  int miscompares = 0, cmp_count = 0;

  always #20 mclk_i = ~mclk_i;

  trig_unit DUT (.*);

  // ------------
  // Tasks
  // ------------
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Counts trigger pulses; first is the cycle index after the rise
  task automatic pulse(input int b, hi, lo, input bit thr,
                       output int cnt, output int first);
    cnt = 0;
    first = -1;
    @(posedge mclk_i);
    lvl_cmp_i[b] <= !thr;
    thr_cmp_i[b] <= thr;
    for (int k = 1; k <= hi + lo; k++)
    begin
      @(posedge mclk_i);
      if (k == hi)
      begin
        lvl_cmp_i[b] <= 1'b0;
        thr_cmp_i[b] <= 1'b0;
      end
      #1;
      if (trig_o === 1'b1)
      begin
        cnt++;
        if (first < 0)
          first = k;
      end
    end
  endtask

  task automatic cfg(input trig_type_t t, input slope_t s, input hyst_t h);
    @(posedge mclk_i);
    trig_type_i <= t;
    slope_a_i <= s;
    hyst_a_i <= h;
    src_a_i <= 5'h00;
    src_b_i <= 5'h01;
    msd_present_i <= 1'b0;
    holdoff_en_i <= 1'b0;
    @(posedge mclk_i);
    acq_start_i <= 1'b1;
    @(posedge mclk_i);
    acq_start_i <= 1'b0;
    cyc(6);
  endtask

  task automatic strobe(input logic [2:0] s);
    @(posedge mclk_i);
    {filt_off_i, nr_on_i, hf_on_i} <= s;
    @(posedge mclk_i);
    {filt_off_i, nr_on_i, hf_on_i} <= 3'h0;
    #1;
  endtask

  // ------------
  // Tests
  // ------------
  // source legality table
  task automatic t_src();
    logic [15:0] tbl [10] = '{16'h0000, 16'h0041, 16'h0042, 16'h5043,
      16'h0140, 16'h2141, 16'h9150, 16'h0151, 16'h3140, 16'h6043};
    foreach (tbl[i])
    begin
      @(posedge mclk_i);
      trig_type_i <= trig_type_t'(tbl[i][15:12]);
      src_a_i <= tbl[i][8:4];
      msd_present_i <= tbl[i][1];
      cyc(2);
      #1;
      chk(src_err_o, tbl[i][0]);
    end
    $display("source test done");
  endtask

  task automatic t_edge();
    int c, f;
    cfg(TT_EDGE, SL_RISE, HY_SMALL);
    pulse(0, 6, 6, 0, c, f);
    chk(c, 1);
    chk(f, 2);
    cfg(TT_EDGE, SL_FALL, HY_MED);
    pulse(0, 6, 6, 0, c, f);
    chk(f, 9);
    cfg(TT_EDGE, SL_EITHER, HY_LARGE);
    pulse(0, 2, 8, 0, c, f);
    chk(c, 0);
    pulse(0, 8, 8, 0, c, f);
    chk(c, 2);
    $display("edge test done");
  endtask

  task automatic t_hold();
    int c, f;
    cfg(TT_EDGE, SL_EITHER, HY_SMALL);
    holdoff_en_i <= 1'b1;
    holdoff_cyc_i <= 24'h000014;
    pulse(0, 4, 4, 0, c, f);
    chk(c, 1);
    chk(holdoff_busy_o, 1'b1);
    cyc(20);
    pulse(0, 25, 6, 0, c, f);
    chk(c, 2);
    @(posedge mclk_i);
    acq_stop_i <= 1'b1;
    @(posedge mclk_i);
    acq_stop_i <= 1'b0;
    pulse(0, 4, 4, 0, c, f);
    chk(c, 0);
    $display("hold-off test done");
  endtask

  task automatic t_ab();
    int c, f;
    ab_events_i <= 1'b1;
    ab_count_i <= 16'h0003;
    slope_b_i <= SL_FALL;
    cfg(TT_AB, SL_RISE, HY_SMALL);
    pulse(1, 4, 4, 0, c, f);
    chk(c, 0);
    pulse(0, 4, 4, 0, c, f);
    chk(wait_b_o, 1'b1);
    cfg(TT_AB, SL_RISE, HY_SMALL);
    chk(wait_b_o, 1'b0);
    pulse(0, 4, 4, 0, c, f);
    for (int i = 1; i <= 3; i++)
    begin
      pulse(1, 4, 4, 0, c, f);
      chk(c, i == 3);
    end
    chk(f, 6);
    ab_events_i <= 1'b0;
    ab_delay_i <= 24'h00001E;
    cfg(TT_AB, SL_RISE, HY_SMALL);
    pulse(0, 4, 4, 0, c, f);
    pulse(1, 4, 4, 0, c, f);
    chk(c, 0);
    cyc(25);
    pulse(1, 4, 4, 0, c, f);
    chk(c, 1);
    $display("sequence test done");
  endtask

  task automatic t_width();
    int c, f;
    logic [15:0] tbl [17] = '{16'h00D1, 16'h00C0, 16'h10B1, 16'h10C0,
      16'h20C1, 16'h20D0, 16'h30C0, 16'h30B1, 16'h4141, 16'h40F0,
      16'h4190, 16'h50E1, 16'h51A1, 16'h5140, 16'h2181, 16'h2190,
      16'h31A1};
    cfg(TT_WIDTH, SL_RISE, HY_SMALL);
    ref_i <= 24'h00000C;
    var_i <= 24'h000000;
    ld_refvar_i <= 1'b1;
    @(posedge mclk_i);
    ld_refvar_i <= 1'b0;
    #1;
    chk(hi_o, 24'h00000C);
    foreach (tbl[i])
    begin
      @(posedge mclk_i);
      if (i == 8)
      begin
        lo_i <= 24'h00000F;
        hi_i <= 24'h000019;
        ld_limits_i <= 1'b1;
        @(posedge mclk_i);
        ld_limits_i <= 1'b0;
        #1;
        chk({ref_o, var_o}, 48'h000014000005);
      end
      wcmp_i <= width_cmp_t'(tbl[i][14:12]);
      pulse(0, tbl[i][11:4], 8, 1, c, f);
      chk(c, tbl[i][0]);
    end
    wcmp_i <= WC_GT;
    pulse(0, 40, 8, 0, c, f);
    chk(c, 0);
    $display("width test done");
  endtask

  task automatic t_filt();
    int c, f;
    strobe(3'h3);
    chk({hf_suppress_o, noise_rej_o}, 2'h1);
    strobe(3'h1);
    chk({hf_suppress_o, noise_rej_o}, 2'h2);
    strobe(3'h2);
    cfg(TT_EDGE, SL_RISE, HY_SMALL);
    pulse(0, 10, 4, 0, c, f);
    chk(f, 6);
    strobe(3'h7);
    chk({hf_suppress_o, noise_rej_o}, 2'h0);
    $display("filter test done");
  endtask

  initial
  begin
    {acq_start_i, acq_stop_i, ext_trig_i, lvl_cmp_i, thr_cmp_i, sbus_i,
     dig_i, msd_present_i, hf_on_i, nr_on_i, filt_off_i, ab_events_i,
     src_a_i, src_b_i, ab_delay_i, ref_i, var_i, lo_i, hi_i,
     holdoff_cyc_i, ab_count_i, wpol_neg_i, ld_refvar_i, ld_limits_i,
     holdoff_en_i} = '0;
    trig_type_i = TT_EDGE;
    slope_a_i = SL_RISE;
    slope_b_i = SL_RISE;
    hyst_a_i = HY_SMALL;
    hyst_b_i = HY_SMALL;
    wcmp_i = WC_GT;
    rst_i = 1'b1;
    cyc(12);
    rst_i <= 1'b0;
    t_src();
    t_edge();
    t_hold();
    t_ab();
    t_width();
    t_filt();
    end_sim();
  end

  // Whole run needs well under 3000 cycles
  initial
  begin
    cyc(5000);
    miscompares++;
    end_sim();
  end
endmodule
